/* hw/tlr_byte_reg.v */
// One read/write byte register with reserved-bit masking
`timescale 1ns/1ps
`default_nettype none
module tlr_byte_reg #(
	parameter [7:0] RST_VAL   = 8'h00,
	parameter [7:0] RSVD_MASK = 8'h00
) (
	input  wire       mclk_i,
	input  wire       resetn_i,
	input  wire       wr_en_i,
	input  wire [7:0] wdata_i,
	output reg  [7:0] q_o
);
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q_o <= RST_VAL;
		end else if (wr_en_i) begin
			q_o <= wdata_i & ~RSVD_MASK;
		end
	end
endmodule
`default_nettype wire

/* hw/tlr_regs.v */
// Thermal limit register bank
`timescale 1ns/1ps
`default_nettype none
`include "tlr_consts.vh"
module tlr_regs (
	input  wire        mclk_i,
	input  wire        resetn_i,
	input  wire [7:0]  dev_type_cfg_i,
	input  wire [7:0]  reg_addr_i,
	input  wire        reg_wr_i,
	input  wire [7:0]  reg_wdata_i,
	input  wire        reg_rd_i,
	output reg  [7:0]  reg_rdata_o,
	output reg         reg_rvalid_o,
	output reg         limits_active_o,
	output wire [15:0] high_limit_o,
	output wire [15:0] low_limit_o,
	output wire [15:0] crit_high_limit_o,
	output wire [15:0] crit_low_limit_o
);
	// Address decode
	wire       active;
	wire       wr_ok;
	wire       sel_high_lsb;
	wire       sel_high_msb;
	wire       sel_low_lsb;
	wire       sel_low_msb;
	wire       sel_chigh_lsb;
	wire       sel_chigh_msb;
	wire       sel_clow_lsb;
	wire       sel_clow_msb;

	// Per-byte write enables
	wire       we_high_lsb;
	wire       we_high_msb;
	wire       we_low_lsb;
	wire       we_low_msb;
	wire       we_chigh_lsb;
	wire       we_chigh_msb;
	wire       we_clow_lsb;
	wire       we_clow_msb;

	// Stored threshold bytes
	wire [7:0] high_lsb_q;
	wire [7:0] high_msb_q;
	wire [7:0] low_lsb_q;
	wire [7:0] low_msb_q;
	wire [7:0] chigh_lsb_q;
	wire [7:0] chigh_msb_q;
	wire [7:0] clow_lsb_q;
	wire [7:0] clow_msb_q;

	// Next values of the port registers
	reg  [7:0] rdata_next;
	reg        rvalid_next;
	reg        active_next;

	assign active        = (dev_type_cfg_i == `TLR_DEV_TYPE_THERMAL);
	assign wr_ok         = reg_wr_i & active;
	assign sel_high_lsb  = (reg_addr_i == `TLR_ADDR_HIGH_LSB);
	assign sel_high_msb  = (reg_addr_i == `TLR_ADDR_HIGH_MSB);
	assign sel_low_lsb   = (reg_addr_i == `TLR_ADDR_LOW_LSB);
	assign sel_low_msb   = (reg_addr_i == `TLR_ADDR_LOW_MSB);
	assign sel_chigh_lsb = (reg_addr_i == `TLR_ADDR_CHIGH_LSB);
	assign sel_chigh_msb = (reg_addr_i == `TLR_ADDR_CHIGH_MSB);
	assign sel_clow_lsb  = (reg_addr_i == `TLR_ADDR_CLOW_LSB);
	assign sel_clow_msb  = (reg_addr_i == `TLR_ADDR_CLOW_MSB);

	assign we_high_lsb   = wr_ok & sel_high_lsb;
	assign we_high_msb   = wr_ok & sel_high_msb;
	assign we_low_lsb    = wr_ok & sel_low_lsb;
	assign we_low_msb    = wr_ok & sel_low_msb;
	assign we_chigh_lsb  = wr_ok & sel_chigh_lsb;
	assign we_chigh_msb  = wr_ok & sel_chigh_msb;
	assign we_clow_lsb   = wr_ok & sel_clow_lsb;
	assign we_clow_msb   = wr_ok & sel_clow_msb;

	tlr_byte_reg #(
		.RST_VAL   (`TLR_RST_HIGH_LSB),
		.RSVD_MASK (`TLR_RSVD_MASK)
	) u_high_lsb (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.wr_en_i  (we_high_lsb),
		.wdata_i  (reg_wdata_i),
		.q_o      (high_lsb_q)
	);

	tlr_byte_reg #(
		.RST_VAL   (`TLR_RST_HIGH_MSB),
		.RSVD_MASK (`TLR_RSVD_MASK)
	) u_high_msb (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.wr_en_i  (we_high_msb),
		.wdata_i  (reg_wdata_i),
		.q_o      (high_msb_q)
	);

	tlr_byte_reg #(
		.RST_VAL   (`TLR_RST_LOW_LSB),
		.RSVD_MASK (`TLR_RSVD_MASK)
	) u_low_lsb (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.wr_en_i  (we_low_lsb),
		.wdata_i  (reg_wdata_i),
		.q_o      (low_lsb_q)
	);

	tlr_byte_reg #(
		.RST_VAL   (`TLR_RST_LOW_MSB),
		.RSVD_MASK (`TLR_RSVD_MASK)
	) u_low_msb (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.wr_en_i  (we_low_msb),
		.wdata_i  (reg_wdata_i),
		.q_o      (low_msb_q)
	);

	tlr_byte_reg #(
		.RST_VAL   (`TLR_RST_CHIGH_LSB),
		.RSVD_MASK (`TLR_RSVD_MASK)
	) u_chigh_lsb (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.wr_en_i  (we_chigh_lsb),
		.wdata_i  (reg_wdata_i),
		.q_o      (chigh_lsb_q)
	);

	tlr_byte_reg #(
		.RST_VAL   (`TLR_RST_CHIGH_MSB),
		.RSVD_MASK (`TLR_RSVD_MASK)
	) u_chigh_msb (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.wr_en_i  (we_chigh_msb),
		.wdata_i  (reg_wdata_i),
		.q_o      (chigh_msb_q)
	);

	tlr_byte_reg #(
		.RST_VAL   (`TLR_RST_CLOW_LSB),
		.RSVD_MASK (`TLR_RSVD_MASK)
	) u_clow_lsb (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.wr_en_i  (we_clow_lsb),
		.wdata_i  (reg_wdata_i),
		.q_o      (clow_lsb_q)
	);

	tlr_byte_reg #(
		.RST_VAL   (`TLR_RST_CLOW_MSB),
		.RSVD_MASK (`TLR_RSVD_MASK)
	) u_clow_msb (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.wr_en_i  (we_clow_msb),
		.wdata_i  (reg_wdata_i),
		.q_o      (clow_msb_q)
	);

	// Byte pairs form the 16-bit limits
	assign high_limit_o      = {high_msb_q, high_lsb_q};
	assign low_limit_o       = {low_msb_q, low_lsb_q};
	assign crit_high_limit_o = {chigh_msb_q, chigh_lsb_q};
	assign crit_low_limit_o  = {clow_msb_q, clow_lsb_q};

	// Read data select, zero when not applicable
	always @* begin
		rdata_next = 8'h00;
		if (active) begin
			case (reg_addr_i)
				`TLR_ADDR_HIGH_LSB: begin
					rdata_next = high_lsb_q & ~`TLR_RSVD_MASK;
				end
				`TLR_ADDR_HIGH_MSB: begin
					rdata_next = high_msb_q & ~`TLR_RSVD_MASK;
				end
				`TLR_ADDR_LOW_LSB: begin
					rdata_next = low_lsb_q & ~`TLR_RSVD_MASK;
				end
				`TLR_ADDR_LOW_MSB: begin
					rdata_next = low_msb_q & ~`TLR_RSVD_MASK;
				end
				`TLR_ADDR_CHIGH_LSB: begin
					rdata_next = chigh_lsb_q & ~`TLR_RSVD_MASK;
				end
				`TLR_ADDR_CHIGH_MSB: begin
					rdata_next = chigh_msb_q & ~`TLR_RSVD_MASK;
				end
				`TLR_ADDR_CLOW_LSB: begin
					rdata_next = clow_lsb_q & ~`TLR_RSVD_MASK;
				end
				`TLR_ADDR_CLOW_MSB: begin
					rdata_next = clow_msb_q & ~`TLR_RSVD_MASK;
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	// Read strobe and applicability flag
	always @* begin
		rvalid_next = reg_rd_i;
		active_next = active;
	end

	// Read data holds until the next read
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_next;
		end
	end

	// Read valid pulse and applicability output
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rvalid_o    <= 1'b0;
			limits_active_o <= 1'b0;
		end else begin
			reg_rvalid_o    <= rvalid_next;
			limits_active_o <= active_next;
		end
	end
endmodule
`default_nettype wire

/* include/tlr_consts.vh */
// Constants for the thermal limit register bank
`ifndef TLR_CONSTS_VH
`define TLR_CONSTS_VH

`define TLR_ADDR_W           8
`define TLR_DATA_W           8
`define TLR_NUM_REGS         8
`define TLR_ADDR_FIRST       8'h1C
`define TLR_ADDR_HIGH_LSB    8'h1C
`define TLR_ADDR_HIGH_MSB    8'h1D
`define TLR_ADDR_LOW_LSB     8'h1E
`define TLR_ADDR_LOW_MSB     8'h1F
`define TLR_ADDR_CHIGH_LSB   8'h20
`define TLR_ADDR_CHIGH_MSB   8'h21
`define TLR_ADDR_CLOW_LSB    8'h22
`define TLR_ADDR_CLOW_MSB    8'h23
`define TLR_RST_HIGH_LSB     8'h70
`define TLR_RST_HIGH_MSB     8'h03
`define TLR_RST_LOW_LSB      8'h00
`define TLR_RST_LOW_MSB      8'h00
`define TLR_RST_CHIGH_LSB    8'h50
`define TLR_RST_CHIGH_MSB    8'h05
`define TLR_RST_CLOW_LSB     8'h00
`define TLR_RST_CLOW_MSB     8'h00
`define TLR_RSVD_MASK        8'h00
`define TLR_DEV_TYPE_THERMAL 8'h18

`endif

/* tb/tb.sv */
// Bench for the limit bank
`timescale 1ns/1ps
`default_nettype none
`include "tlr_consts.vh"
module tb;
	logic                           mclk_i = 0, resetn_i = 0, reg_rvalid_o, limits_active_o;
	logic [7:0]                     dev_type_cfg_i = 8'h18, reg_rdata_o, d;
	wire logic [7:0]                reg_addr_i, reg_wdata_i;
	wire logic                      reg_wr_i, reg_rd_i;
	logic [15:0]                    high_limit_o, low_limit_o, crit_high_limit_o, crit_low_limit_o;
	int                             n_errors = 0, n_tests = 0;
	logic [7:0] rt [8] = '{8'h70, 8'h03, 8'h00, 8'h00, 8'h50, 8'h05, 8'h00, 8'h00};
	logic [7:0] wt [8] = '{8'hA5, 8'h5A, 8'h3C, 8'h40, 8'hFF, 8'h7F, 8'h00, 8'h01};
	// Write order keeps critical high above high and critical low below low
	int         ord [8] = '{4, 5, 0, 1, 2, 3, 6, 7};
	tlr_regs u_dut (
		.mclk_i            (mclk_i),
		.resetn_i          (resetn_i),
		.dev_type_cfg_i    (dev_type_cfg_i),
		.reg_addr_i        (reg_addr_i),
		.reg_wr_i          (reg_wr_i),
		.reg_wdata_i       (reg_wdata_i),
		.reg_rd_i          (reg_rd_i),
		.reg_rdata_o       (reg_rdata_o),
		.reg_rvalid_o      (reg_rvalid_o),
		.limits_active_o   (limits_active_o),
		.high_limit_o      (high_limit_o),
		.low_limit_o       (low_limit_o),
		.crit_high_limit_o (crit_high_limit_o),
		.crit_low_limit_o  (crit_low_limit_o)
	);
	tlr_host u_host (
		.mclk_i      (mclk_i),
		.reg_rdata_o (reg_rdata_o),
		.reg_wr_i    (reg_wr_i),
		.reg_rd_i    (reg_rd_i),
		.reg_addr_i  (reg_addr_i),
		.reg_wdata_i (reg_wdata_i)
	);
	initial forever #5 mclk_i = ~mclk_i;
	task automatic chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", name, e, g);
		end
	endtask
	task automatic chk_word(input string name, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", name, e, g);
		end
	endtask
	task automatic chk_bit(input string name, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %b got %b", name, e, g);
		end
	endtask
	task give_verdict;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Watchdog, the tests need well under 150 cycles
	initial begin
		#5000;
		n_errors++;
		give_verdict;
	end
	initial begin
		repeat (5) @(posedge mclk_i);
		#1 resetn_i = 1;
		for (int i = 0; i < 8; i++) begin
			u_host.rd(8'(`TLR_ADDR_FIRST + ord[i]), d);
			chk_byte("reset byte", rt[ord[i]], d);
			chk_bit("read valid", 1'b1, reg_rvalid_o);
			u_host.wr(8'(`TLR_ADDR_FIRST + ord[i]), wt[ord[i]]);
			u_host.rd(8'(`TLR_ADDR_FIRST + ord[i]), d);
			chk_byte("written byte", wt[ord[i]], d);
		end
		chk_word("high limit", 16'h5AA5, high_limit_o);
		chk_word("low limit", 16'h403C, low_limit_o);
		chk_word("crit high limit", 16'h7FFF, crit_high_limit_o);
		chk_word("crit low limit", 16'h0100, crit_low_limit_o);
		chk_bit("limits active", 1'b1, limits_active_o);
		u_host.rd(8'h24, d);
		chk_byte("unmapped read", 8'h00, d);
		@(posedge mclk_i) #1 dev_type_cfg_i = 8'h00;
		u_host.wr(`TLR_ADDR_HIGH_LSB, 8'h11);
		u_host.rd(`TLR_ADDR_HIGH_MSB, d);
		chk_byte("inactive read", 8'h00, d);
		chk_word("inactive write", 16'h5AA5, high_limit_o);
		chk_bit("limits inactive", 1'b0, limits_active_o);
		@(posedge mclk_i) #1 dev_type_cfg_i = 8'h18;
		resetn_i = 0;
		repeat (2) @(posedge mclk_i);
		#1 resetn_i = 1;
		chk_word("reset high limit", {`TLR_RST_HIGH_MSB, `TLR_RST_HIGH_LSB}, high_limit_o);
		chk_word("reset crit low limit", 16'h0000, crit_low_limit_o);
		chk_bit("reset read valid", 1'b0, reg_rvalid_o);
		u_host.rd(`TLR_ADDR_CHIGH_MSB, d);
		chk_byte("reset crit high byte", `TLR_RST_CHIGH_MSB, d);
		give_verdict;
	end
endmodule
bind tlr_regs tlr_regs_monitor u_mon (
	.mclk_i           (mclk_i),
	.resetn_i         (resetn_i),
	.reg_wr_i         (reg_wr_i),
	.reg_rd_i         (reg_rd_i),
	.reg_rvalid_o     (reg_rvalid_o),
	.limits_active_o  (limits_active_o),
	.dev_type_cfg_i   (dev_type_cfg_i),
	.reg_addr_i       (reg_addr_i),
	.reg_wdata_i      (reg_wdata_i),
	.reg_rdata_o      (reg_rdata_o),
	.high_limit_o     (high_limit_o),
	.crit_low_limit_o (crit_low_limit_o)
);
`default_nettype wire

/* tb/tlr_host.sv */
// Host model on the register port
`timescale 1ns/1ps
`default_nettype none
`include "tlr_consts.vh"
module tlr_host (
	input  wire logic       mclk_i,
	input  wire logic [7:0] reg_rdata_o,
	output logic            reg_wr_i,
	output logic            reg_rd_i,
	output logic [7:0]      reg_addr_i,
	output logic [7:0]      reg_wdata_i
);
	initial begin
		reg_wr_i    = 1'b0;
		reg_rd_i    = 1'b0;
		reg_addr_i  = 8'h00;
		reg_wdata_i = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk_i) #1;
		{reg_addr_i, reg_wdata_i, reg_wr_i} = {a, v & ~`TLR_RSVD_MASK, 1'b1};
		@(posedge mclk_i) #1;
		{reg_addr_i, reg_wdata_i, reg_wr_i} = {~a, ~v, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i) #1;
		{reg_addr_i, reg_rd_i} = {a, 1'b1};
		@(posedge mclk_i) #1;
		{reg_addr_i, reg_rd_i} = {~a, 1'b0};
		d = reg_rdata_o;
	endtask
endmodule
`default_nettype wire

/* tb/tlr_regs_monitor.sv */
// Port checks for the limit bank
`timescale 1ns/1ps
`default_nettype none
`include "tlr_consts.vh"
module tlr_regs_monitor (
	input wire logic        mclk_i,
	input wire logic        resetn_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic        reg_rvalid_o,
	input wire logic        limits_active_o,
	input wire logic [7:0]  dev_type_cfg_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic [15:0] high_limit_o,
	input wire logic [15:0] crit_low_limit_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	wire logic on = (dev_type_cfg_i == `TLR_DEV_TYPE_THERMAL);
	wire logic rd = reg_rd_i && on && !reg_wr_i;
	a_rd_pulse: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no rvalid");
	a_rd_quiet: assert property (!reg_rd_i |=> !reg_rvalid_o && $stable(reg_rdata_o)) else $error("stray");
	a_cfg_on: assert property (on |=> limits_active_o) else $error("inactive");
	a_wr_refused: assert property (!on |=> $stable(high_limit_o)) else $error("wr taken");
	a_rd_refused: assert property (reg_rd_i && !on |=> reg_rdata_o == 8'h00) else $error("rd data");
	a_wr_low: assert property (reg_wr_i && on && reg_addr_i == `TLR_ADDR_HIGH_LSB
		|=> high_limit_o[7:0] == $past(reg_wdata_i)) else $error("wr lost");
	a_rd_high: assert property (rd && reg_addr_i == `TLR_ADDR_HIGH_MSB
		|=> reg_rdata_o == $past(high_limit_o[15:8])) else $error("rd high");
	a_rd_clow: assert property (rd && reg_addr_i == `TLR_ADDR_CLOW_MSB
		|=> reg_rdata_o == $past(crit_low_limit_o[15:8])) else $error("rd clow");
endmodule
`default_nettype wire
